// ==== bench/complementary_pwm_extras_and_irq_tb.sv ====
`include "cpx_consts.svh"
module complementary_pwm_extras_and_irq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// signals
	// ****
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, bus_ctrl_lock = 0, osc_stopped = 0;
	logic [3:0]  halt_in_n = 4'hF, ext_ovf_ev = 4'h0;
	logic pos_a = 0, pos_b = 0, pos_c = 0, other_ch_clear = 0;
	logic [15:0] ext_match_ev = 16'h0;
	logic [1:0]  ext_udf_ev = 2'h0;
	logic [16:0] dtc_ack = 17'h0, dtc_req;
	logic [4:0]  dma_ack = 5'h0, dma_req, irq_id;
	logic [22:0] irq;
	logic ch3_pin, ch3_oe, adc_start, irq_any;
	cpx_pkg::cpx_pwm_t pwm;
	logic [6:0]  obs;
	logic [2:0]  phase_v;
	int          shoot_cnt, failures = 0, tests_run = 0;
	assign obs = {ch3_pin, pwm.lvl};
	always #25 pclk = ~pclk;
	cpx_top cpx_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .bus_ctrl_lock(bus_ctrl_lock),
		.halt_in_n(halt_in_n), .osc_stopped(osc_stopped),
		.position_input_a(pos_a), .position_input_b(pos_b),
		.position_input_c(pos_c), .other_ch_clear(other_ch_clear),
		.ext_match_ev(ext_match_ev), .ext_ovf_ev(ext_ovf_ev),
		.ext_udf_ev(ext_udf_ev), .dtc_ack(dtc_ack), .dma_ack(dma_ack),
		.pwm_q(pwm), .ch3_compare_pin_a(ch3_pin),
		.ch3_compare_oe(ch3_oe), .adc_start_q(adc_start), .irq_q(irq),
		.irq_any_q(irq_any), .irq_id_q(irq_id), .dtc_req_q(dtc_req),
		.dma_req_q(dma_req));
	cpx_inverter_model cpx_inverter_model_i (.pclk(pclk), .pwm(pwm),
		.phase_v(phase_v), .shoot_cnt(shoot_cnt));
	// ****
	// helpers
	// ****
	task automatic chk(input string w, input logic [31:0] x,
		input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", w, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
			failures++;
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		#1;
	endtask
	task automatic wait_c(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task automatic ev(input logic [15:0] m, input logic [3:0] o,
		input logic [1:0] u);
		@(posedge pclk);
		{ext_match_ev, ext_ovf_ev, ext_udf_ev} <= {m, o, u};
		@(posedge pclk);
		{ext_match_ev, ext_ovf_ev, ext_udf_ev} <= 22'h0;
		wait_c(1);
	endtask
	task automatic clr();
		apb(0, `CPX_OFF_FLAG, 0);
		apb(1, `CPX_OFF_FLAG, 0);
	endtask
	task automatic watch(input int b, output logic [31:0] on,
		output logic [31:0] chg);
		logic p;
		{on, chg} = 64'h0;
		p = obs[b];
		repeat (150) begin
			wait_c(1);
			on += obs[b];
			chg += (obs[b] != p);
			p = obs[b];
		end
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_regs();
		chk("pin3 init", 1'b1, ch3_pin);
		apb(0, `CPX_OFF_OCR, 0);
		chk("ocr", 32'h7E, r);
		apb(0, `CPX_OFF_UPPER, 0);
		chk("upper", 32'hFFFF, r);
		apb(0, 8'hFC, 0);
		chk("unmapped err", 1'b1, e);
	endtask
	task automatic t_flags();
		apb(1, `CPX_OFF_IER, 32'h2);
		ev(16'h0006, 4'h0, 2'h0);
		chk("irq1", 1'b1, irq[1]);
		chk("irq2 masked", 1'b0, irq[2]);
		apb(1, `CPX_OFF_FLAG, 0);
		chk("unread clear", 1'b1, irq[1]);
		apb(0, `CPX_OFF_FLAG, 0);
		chk("flags", 32'h6, r);
		apb(1, `CPX_OFF_FLAG, 0);
		chk("cleared", 1'b0, irq[1]);
		apb(1, `CPX_OFF_IER, 32'h7F0000);
		ev(16'h0, 4'hF, 2'h3);
		chk("ovf udf", 7'h6F, irq[22:16]);
		clr();
		apb(1, `CPX_OFF_IER, 32'h10032);
		ev(16'h0030, 4'h0, 2'h0);
		chk("rank ch1", 5'h04, irq_id);
		ev(16'h0, 4'h1, 2'h0);
		chk("rank ch0 ovf", 5'h10, irq_id);
		ev(16'h0002, 4'h0, 2'h0);
		chk("rank ch0 b", 5'h01, irq_id);
		chk("irq any", 1'b1, irq_any);
		clr();
	endtask
	task automatic t_xfer();
		apb(1, `CPX_OFF_IER, 32'h1153);
		ev(16'h1153, 4'h0, 2'h0);
		chk("dma req", 5'h1F, dma_req);
		chk("dtc req", 16'h1153, dtc_req[15:0]);
		@(posedge pclk);
		{dma_ack, dtc_ack} <= {5'h01, 17'h2};
		@(posedge pclk);
		{dma_ack, dtc_ack} <= 22'h0;
		wait_c(1);
		chk("auto clear", 2'h0, irq[1:0]);
		clr();
	endtask
	task automatic t_adc();
		logic [15:0] m[4] = '{16'h0001, 16'h0010, 16'h0040, 16'h1000};
		logic [31:0] n;
		for (int i = 0; i < 8; i++) begin
			apb(1, `CPX_OFF_IER, {8'h0, i[0], 23'h0});
			n = 0;
			@(posedge pclk);
			ext_match_ev <= m[i/2];
			@(posedge pclk);
			ext_match_ev <= 16'h0;
			#1;
			repeat (4) begin
				n += adc_start;
				wait_c(1);
			end
			chk("adc start", i[0] && i < 6, n);
		end
		clr();
	endtask
	task automatic t_lock();
		@(posedge pclk);
		bus_ctrl_lock <= 1'b1;
		apb(1, `CPX_OFF_UPPER, 32'h0123);
		apb(0, `CPX_OFF_UPPER, 0);
		chk("locked upper", 32'hFFFF, r);
		apb(1, `CPX_OFF_DUTY_U, 32'h0042);
		apb(0, `CPX_OFF_DUTY_U, 0);
		chk("duty open", 32'h42, r);
		@(posedge pclk);
		bus_ctrl_lock <= 1'b0;
	endtask
	task automatic t_wave();
		logic [31:0] a, c;
		apb(1, `CPX_OFF_UPPER, 32'h20);
		apb(1, `CPX_OFF_DEAD, 32'h4);
		apb(1, `CPX_OFF_DUTY_U, 32'h0);
		apb(1, `CPX_OFF_TCR, 32'h08);
		wait_c(80);
		watch(0, a, c);
		chk("duty 100", 32'h96, a);
		apb(1, `CPX_OFF_DUTY_U, 32'h20);
		wait_c(80);
		watch(0, a, c);
		chk("duty 0", 32'h0, a);
		watch(6, a, c);
		chk("no toggle", 32'h0, c);
		apb(1, `CPX_OFF_OCR, 32'h7F);
		watch(6, a, c);
		chk("toggle oe", 1'b1, ch3_oe);
		chk("toggle count", 1'b1, c == 5 || c == 6);
		apb(1, `CPX_OFF_OCR, 32'h7E);
		wait_c(2);
		chk("toggle off", 1'b1, ch3_pin);
		apb(1, `CPX_OFF_IER, 32'h100000);
		wait_c(60);
		chk("ch4 ovf dtc", 1'b1, dtc_req[16]);
		apb(1, `CPX_OFF_SYNC, 32'h1);
		apb(1, `CPX_OFF_TCR, 32'h0B);
		for (int k = 0; k < 3; k++) begin
			wait_c(9 * k + 3);
			@(posedge pclk);
			other_ch_clear <= 1'b1;
			@(posedge pclk);
			other_ch_clear <= 1'b0;
			apb(0, `CPX_OFF_CNT, 0);
			chk("sync clear", 1'b1, r[31:16] < 16'h0008);
		end
	endtask
	task automatic t_motor();
		logic [31:0] a, c;
		apb(1, `CPX_OFF_DUTY_U, 32'h10);
		apb(1, `CPX_OFF_GCR, 32'h49);
		wait_c(4);
		chk("sw pos 1", 6'h11, pwm.lvl);
		apb(1, `CPX_OFF_GCR, 32'h4B);
		wait_c(4);
		chk("sw pos 3", 6'h21, pwm.lvl);
		apb(1, `CPX_OFF_GCR, 32'h40);
		@(posedge pclk);
		pos_a <= 1'b1;
		wait_c(5);
		chk("hall pos 1", 6'h11, pwm.lvl);
		@(posedge pclk);
		pos_b <= 1'b1;
		wait_c(5);
		chk("hall pos 3", 6'h21, pwm.lvl);
		apb(1, `CPX_OFF_GCR, 32'h50);
		watch(0, a, c);
		chk("chopped", 1'b1, c > 0);
		watch(5, a, c);
		chk("steady low", 32'h96, a);
		chk("phase w low", 1'b0, phase_v[2]);
		chk("driven", 6'h3F, pwm.oe);
		for (int i = 0; i < 5; i++) begin
			@(posedge pclk);
			halt_in_n <= i < 4 ? ~(4'h1 << i) : 4'hF;
			osc_stopped <= i == 4;
			wait_c(2);
			chk("floated", 6'h00, pwm.oe);
			@(posedge pclk);
			{halt_in_n, osc_stopped} <= 5'h1E;
			wait_c(3);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****
	// sequence
	// ****
	initial begin
		#1500000;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_flags();
		t_xfer();
		t_adc();
		t_lock();
		t_wave();
		t_motor();
		chk("no shoot through", 32'h0, shoot_cnt);
		end_of_test();
	end
endmodule // complementary_pwm_extras_and_irq_tb

// ==== bench/cpx_inverter_model.sv ====
module cpx_inverter_model (
	input  wire logic              pclk,
	input  wire cpx_pkg::cpx_pwm_t pwm,
	output logic [2:0]             phase_v,
	output int                     shoot_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// power legs
	// ****
	initial begin
		phase_v = 3'h0;
		shoot_cnt = 0;
	end
	// a floated leg is not held, so the node drifts instead of keeping level
	always @(posedge pclk) begin
		for (int i = 0; i < 3; i++) begin
			if (pwm.oe[i] && pwm.lvl[i])
				phase_v[i] = 1'b1;
			else if (pwm.oe[i+3] && pwm.lvl[i+3])
				phase_v[i] = 1'b0;
			else
				phase_v[i] = ~phase_v[i];
			if (&{pwm.oe[i], pwm.oe[i+3], pwm.lvl[i], pwm.lvl[i+3]})
				shoot_cnt++;
		end
	end
endmodule // cpx_inverter_model

// ==== rtl/cpx_consts.svh ====
`ifndef CPX_CONSTS_SVH
`define CPX_CONSTS_SVH

// register byte offsets
`define CPX_OFF_OCR    8'h00
`define CPX_OFF_TCR    8'h04
`define CPX_OFF_SYNC   8'h08
`define CPX_OFF_GCR    8'h0C
`define CPX_OFF_UPPER  8'h10
`define CPX_OFF_DEAD   8'h14
`define CPX_OFF_DUTY_U 8'h18
`define CPX_OFF_DUTY_V 8'h1C
`define CPX_OFF_DUTY_W 8'h20
`define CPX_OFF_IER    8'h24
`define CPX_OFF_FLAG   8'h28
`define CPX_OFF_CNT    8'h2C

// field positions
`define CPX_OCR_TOGGLE 0
`define CPX_TCR_RUN    3
`define CPX_GCR_SRC    3
`define CPX_GCR_CHOP_P 4
`define CPX_GCR_CHOP_N 5
`define CPX_GCR_BLDC   6
`define CPX_IER_ADC    23
`define CPX_CLR_SYNC   3'h3
`define CPX_NFLAG      23

// reset values
`define CPX_RST_UPPER  16'hFFFF
`define CPX_RST_OCR    7'h7E
`endif

// ==== rtl/cpx_flag_bank.sv ====
`include "cpx_consts.svh"
module cpx_flag_bank #(
	parameter int N = `CPX_NFLAG
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [N-1:0] set_ev,
	input  wire logic         rd_stb,
	input  wire logic         wr_stb,
	input  wire logic [N-1:0] wdata,
	input  wire logic [N-1:0] auto_clr,
	input  wire logic [N-1:0] en,
	output logic      [N-1:0] flags_q,
	output logic      [N-1:0] irq_q
);
	logic [N-1:0] seen_q;
	logic [N-1:0] clr;

	// a zero write only clears a flag that was read as 1 beforehand
	assign clr = (wr_stb ? (~wdata & seen_q) : '0) | auto_clr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= '0;
		end else begin
			// set wins over a clear in the same cycle
			flags_q <= (flags_q & ~clr) | set_ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_q <= '0;
		end else if (rd_stb) begin
			seen_q <= flags_q;
		end else if (wr_stb) begin
			seen_q <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= '0;
		end else begin
			irq_q <= ((flags_q & ~clr) | set_ev) & en;
		end
	end

	a_flag_irq: assert property (@(posedge pclk) disable iff (!presetn)
		irq_q == (flags_q & $past(en)))
		else $error("irq not flag and enable");
	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		|set_ev |=> ((flags_q & $past(set_ev)) == $past(set_ev)))
		else $error("event lost");
endmodule // cpx_flag_bank

// ==== rtl/cpx_pkg.sv ====
package cpx_pkg;
	// six power-stage pins: levels and drive enables
	typedef struct packed {
		logic [5:0] lvl;
		logic [5:0] oe;
	} cpx_pwm_t;
	// apb answer
	typedef struct packed {
		logic        ready;
		logic        slverr;
		logic [31:0] rdata;
	} cpx_apb_rsp_t;
endpackage

// ==== rtl/cpx_top.sv ====
`include "cpx_consts.svh"
module cpx_top #(
	parameter int CNT_DIV = 1
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic [31:0]            prdata,
	input  wire logic              bus_ctrl_lock,
	input  wire logic [3:0]        halt_in_n,
	input  wire logic              osc_stopped,
	input  wire logic              position_input_a,
	input  wire logic              position_input_b,
	input  wire logic              position_input_c,
	input  wire logic              other_ch_clear,
	input  wire logic [15:0]       ext_match_ev,
	input  wire logic [3:0]        ext_ovf_ev,
	input  wire logic [1:0]        ext_udf_ev,
	input  wire logic [16:0]       dtc_ack,
	input  wire logic [4:0]        dma_ack,
	output cpx_pkg::cpx_pwm_t      pwm_q,
	output logic                   ch3_compare_pin_a,
	output logic                   ch3_compare_oe,
	output logic                   adc_start_q,
	output logic [22:0]            irq_q,
	output logic                   irq_any_q,
	output logic [4:0]             irq_id_q,
	output logic [16:0]            dtc_req_q,
	output logic [4:0]             dma_req_q
);
	localparam int NF = `CPX_NFLAG;
	// flag bit of each dma source: A match of ch0..ch4
	localparam logic [4:0] DMA_IDX [5] = '{5'h00, 5'h04, 5'h06, 5'h08, 5'h0C};
	// fixed ranking, highest first
	localparam logic [4:0] RANK [NF] = '{
		5'h00, 5'h01, 5'h02, 5'h03, 5'h10,
		5'h04, 5'h05, 5'h11, 5'h15,
		5'h06, 5'h07, 5'h12, 5'h16,
		5'h08, 5'h09, 5'h0A, 5'h0B, 5'h13,
		5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h14};

	// ****************************************
	// register file
	// ****************************************
	logic [6:0]  ocr_q;
	logic [3:0]  tcr_q;
	logic        sync_q;
	logic [6:0]  gcr_q;
	logic [15:0] upper_q;
	logic [15:0] dead_q;
	logic [15:0] duty_q [3];
	logic [23:0] ier_q;
	logic [15:0] cnt4_q;
	logic        down_q;
	logic        rsp_rdy_q;
	logic        rsp_err_q;
	logic [31:0] rsp_data_q;
	logic        setup;
	logic        acc;
	logic        wr;
	logic        wr_prot;
	logic        mapped;
	logic [31:0] rd_mux;
	logic [NF-1:0] flags;
	logic [15:0] cnt3;

	assign setup = psel & ~penable;
	assign acc = psel & penable & rsp_rdy_q;
	assign wr = acc & pwrite;
	// buffer (duty) registers stay writable under the lock
	assign wr_prot = wr & ~bus_ctrl_lock;
	assign cnt3 = cnt4_q + dead_q;
	assign pready = rsp_rdy_q;
	assign pslverr = rsp_err_q;
	assign prdata = rsp_data_q;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`CPX_OFF_OCR:    rd_mux = {25'h0, ocr_q};
			`CPX_OFF_TCR:    rd_mux = {28'h0, tcr_q};
			`CPX_OFF_SYNC:   rd_mux = {31'h0, sync_q};
			`CPX_OFF_GCR:    rd_mux = {25'h0, gcr_q};
			`CPX_OFF_UPPER:  rd_mux = {16'h0, upper_q};
			`CPX_OFF_DEAD:   rd_mux = {16'h0, dead_q};
			`CPX_OFF_DUTY_U: rd_mux = {16'h0, duty_q[0]};
			`CPX_OFF_DUTY_V: rd_mux = {16'h0, duty_q[1]};
			`CPX_OFF_DUTY_W: rd_mux = {16'h0, duty_q[2]};
			`CPX_OFF_IER:    rd_mux = {8'h0, ier_q};
			`CPX_OFF_FLAG:   rd_mux = {9'h0, flags};
			`CPX_OFF_CNT:    rd_mux = {cnt4_q, cnt3};
			default:         mapped = 1'b0;
		endcase
	end

	// zero wait states: answer is ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_rdy_q <= 1'b0;
			rsp_err_q <= 1'b0;
			rsp_data_q <= 32'h0000_0000;
		end else begin
			rsp_rdy_q <= setup;
			rsp_err_q <= setup & ~mapped;
			rsp_data_q <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ocr_q <= `CPX_RST_OCR;
			tcr_q <= 4'h0;
			sync_q <= 1'b0;
			gcr_q <= 7'h00;
			upper_q <= `CPX_RST_UPPER;
			dead_q <= 16'h0000;
			ier_q <= 24'h00_0000;
		end else if (wr_prot) begin
			unique case (paddr)
				`CPX_OFF_OCR:   ocr_q <= pwdata[6:0];
				`CPX_OFF_TCR:   tcr_q <= pwdata[3:0];
				`CPX_OFF_SYNC:  sync_q <= pwdata[0];
				`CPX_OFF_GCR:   gcr_q <= pwdata[6:0];
				`CPX_OFF_UPPER: upper_q <= pwdata[15:0];
				`CPX_OFF_DEAD:  dead_q <= pwdata[15:0];
				`CPX_OFF_IER:   ier_q <= pwdata[23:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_q <= '{16'h0000, 16'h0000, 16'h0000};
		end else if (wr) begin
			unique case (paddr)
				`CPX_OFF_DUTY_U: duty_q[0] <= pwdata[15:0];
				`CPX_OFF_DUTY_V: duty_q[1] <= pwdata[15:0];
				`CPX_OFF_DUTY_W: duty_q[2] <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// carrier counters
	// ****************************************
	logic [7:0]  div_q;
	logic        tick;
	logic        run;
	logic        sync_clr;
	logic [15:0] cdr;
	logic        c3_top;
	logic        c4_zero;

	assign run = tcr_q[`CPX_TCR_RUN];
	assign cdr = upper_q - dead_q;
	assign tick = (div_q == 8'(CNT_DIV - 1)) & run;
	assign sync_clr = sync_q & (tcr_q[2:0] == `CPX_CLR_SYNC)
		& other_ch_clear;
	assign c3_top = tick & (cnt3 == upper_q);
	assign c4_zero = tick & (cnt4_q == 16'h0000);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 8'h00;
		end else if (!run || div_q == 8'(CNT_DIV - 1)) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// counter three is counter four plus the dead time, so clearing
	// counter four (and the direction flag with it) sets counter three to the dead time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt4_q <= 16'h0000;
			down_q <= 1'b0;
		end else if (sync_clr) begin
			cnt4_q <= 16'h0000;
			down_q <= 1'b0;
		end else if (wr_prot && paddr == `CPX_OFF_CNT) begin
			cnt4_q <= pwdata[31:16];
		end else if (tick) begin
			if (!down_q && cnt4_q >= cdr) begin
				down_q <= 1'b1;
				cnt4_q <= cnt4_q - 16'h0001;
			end else if (down_q && cnt4_q == 16'h0000) begin
				down_q <= 1'b0;
				cnt4_q <= 16'h0001;
			end else begin
				cnt4_q <= down_q ? cnt4_q - 16'h0001 : cnt4_q + 16'h0001;
			end
		end
	end

	// ****************************************
	// phase generators
	// ****************************************
	logic [2:0] pos_q;
	logic [2:0] on_m;
	logic [2:0] off_m;

	for (genvar i = 0; i < 3; i++) begin : g_phase
		assign on_m[i] = tick & down_q & (cnt4_q == duty_q[i]);
		assign off_m[i] = tick & ~down_q & (cnt3 == duty_q[i]);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pos_q[i] <= 1'b0;
			end else if (duty_q[i] == 16'h0000) begin
				pos_q[i] <= 1'b1;
			end else if (duty_q[i] == upper_q) begin
				pos_q[i] <= 1'b0;
			end else if (on_m[i] && off_m[i]) begin
				pos_q[i] <= pos_q[i];
			end else if (off_m[i]) begin
				pos_q[i] <= 1'b0;
			end else if (on_m[i]) begin
				pos_q[i] <= 1'b1;
			end
		end
	end

	// ****************************************
	// motor commutation
	// ****************************************
	logic [2:0] hall;
	logic [2:0] hall_prev_q;
	logic [2:0] pat_q;
	logic [5:0] step;

	assign hall = {position_input_c, position_input_b, position_input_a};

	// {high-side u v w, low-side u v w} for each rotor position
	function automatic logic [5:0] cpx_step(input logic [2:0] p);
		unique case (p)
			3'h1:    return 6'h22;
			3'h3:    return 6'h21;
			3'h2:    return 6'h11;
			3'h6:    return 6'h14;
			3'h4:    return 6'h0C;
			3'h5:    return 6'h0A;
			default: return 6'h00;
		endcase
	endfunction

	assign step = cpx_step(pat_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hall_prev_q <= 3'h0;
		end else begin
			hall_prev_q <= hall;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pat_q <= 3'h0;
		end else if (gcr_q[`CPX_GCR_SRC]) begin
			pat_q <= gcr_q[2:0];
		end else if (hall != hall_prev_q) begin
			pat_q <= hall;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	logic [5:0] on_st;
	logic [5:0] lvl_d;
	logic       halt;

	// oscillator-stop comes from the clock monitor; a stopped pclk cannot
	// clock this flop, so the monitor must also hold its own pin release
	assign halt = ~&halt_in_n | osc_stopped;

	for (genvar i = 0; i < 3; i++) begin : g_leg
		always_comb begin
			if (gcr_q[`CPX_GCR_BLDC]) begin
				on_st[i] = step[5-i] &
					(gcr_q[`CPX_GCR_CHOP_P] ? pos_q[i] : 1'b1);
				on_st[i+3] = step[2-i] &
					(gcr_q[`CPX_GCR_CHOP_N] ? ~pos_q[i] : 1'b1);
			end else begin
				on_st[i] = pos_q[i] & run;
				on_st[i+3] = ~pos_q[i] & run;
			end
			lvl_d[i] = on_st[i] ? ocr_q[1+i] : ~ocr_q[1+i];
			lvl_d[i+3] = on_st[i+3] ? ocr_q[4+i] : ~ocr_q[4+i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_q <= '0;
		end else begin
			pwm_q.lvl <= lvl_d;
			pwm_q.oe <= halt ? 6'h00 : 6'h3F;
		end
	end

	// ****************************************
	// carrier toggle and a/d start
	// ****************************************
	logic tog_en;

	assign tog_en = ocr_q[`CPX_OCR_TOGGLE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch3_compare_pin_a <= 1'b1;
			ch3_compare_oe <= 1'b0;
		end else begin
			ch3_compare_oe <= tog_en;
			if (!tog_en) begin
				ch3_compare_pin_a <= 1'b1;
			end else if (c3_top ^ c4_zero) begin
				ch3_compare_pin_a <= ~ch3_compare_pin_a;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_start_q <= 1'b0;
		end else begin
			adc_start_q <= ier_q[`CPX_IER_ADC] & (c3_top |
				ext_match_ev[0] | ext_match_ev[4] | ext_match_ev[6]);
		end
	end

	// ****************************************
	// status flags and requests
	// ****************************************
	logic [NF-1:0] set_ev;
	logic [NF-1:0] auto_clr;
	logic [NF-1:0] irq_w;

	// flags 0..15 matches, 16..20 overflow ch0..4, 21..22 underflow ch1..2
	assign set_ev = {ext_udf_ev, c4_zero & down_q, ext_ovf_ev,
		ext_match_ev[15:9], ext_match_ev[8] | c3_top,
		ext_match_ev[7:0]};

	// transfer-controller ack bit 16 belongs to the ch4 overflow flag
	always_comb begin
		auto_clr = '0;
		auto_clr[15:0] = dtc_ack[15:0];
		auto_clr[20] = dtc_ack[16];
		for (int k = 0; k < 5; k++) begin
			auto_clr[DMA_IDX[k]] = auto_clr[DMA_IDX[k]] | dma_ack[k];
		end
	end

	cpx_flag_bank #(
		.N(NF)
	) u_flags (
		.pclk    (pclk),
		.presetn (presetn),
		.set_ev  (set_ev),
		.rd_stb  (setup & ~pwrite & (paddr == `CPX_OFF_FLAG)),
		.wr_stb  (wr & (paddr == `CPX_OFF_FLAG)),
		.wdata   (pwdata[NF-1:0]),
		.auto_clr(auto_clr),
		.en      (ier_q[NF-1:0]),
		.flags_q (flags),
		.irq_q   (irq_w)
	);

	assign irq_q = irq_w;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_any_q <= 1'b0;
			irq_id_q <= 5'h00;
		end else begin
			irq_any_q <= |irq_w;
			irq_id_q <= 5'h00;
			for (int k = NF - 1; k >= 0; k--) begin
				if (irq_w[RANK[k]]) begin
					irq_id_q <= RANK[k];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dtc_req_q <= 17'h0_0000;
			dma_req_q <= 5'h00;
		end else begin
			dtc_req_q <= {irq_w[20], irq_w[15:0]};
			for (int k = 0; k < 5; k++) begin
				dma_req_q[k] <= irq_w[DMA_IDX[k]];
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	a_full_duty: assert property (@(posedge pclk) disable iff (!presetn)
		duty_q[0] == 16'h0000 |=> pos_q[0]) else $error("u not 100%");
	a_zero_duty: assert property (@(posedge pclk) disable iff (!presetn)
		duty_q[1] == upper_q && duty_q[1] != 16'h0000 |=> !pos_q[1])
		else $error("v not 0%");
	a_tie_hold: assert property (@(posedge pclk) disable iff (!presetn)
		on_m[2] && off_m[2] && duty_q[2] != 16'h0000 &&
		duty_q[2] != upper_q |=> $stable(pos_q[2]))
		else $error("tie changed w");
	a_halt_float: assert property (@(posedge pclk) disable iff (!presetn)
		halt |=> pwm_q.oe == 6'h00) else $error("pins not floated");
	a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
		tog_en && (c3_top ^ c4_zero) |=> ch3_compare_pin_a !=
		$past(ch3_compare_pin_a)) else $error("toggle missed");
	a_sync_clear: assert property (@(posedge pclk) disable iff (!presetn)
		sync_clr |=> cnt4_q == 16'h0000 && cnt3 == dead_q)
		else $error("sync clear failed");
	a_lock_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && bus_ctrl_lock && paddr == `CPX_OFF_UPPER |=> $stable(upper_q))
		else $error("locked write landed");
	a_adc_gate: assert property (@(posedge pclk) disable iff (!presetn)
		adc_start_q |-> $past(ier_q[`CPX_IER_ADC]))
		else $error("adc start while off");
	a_dma_a_only: assert property (@(posedge pclk) disable iff (!presetn)
		dma_req_q[3] |-> $past(irq_w[8])) else $error("dma from non-A");
endmodule // cpx_top
